// File: hdl/reader_status_display_regs.sv
// Purpose: Status display, command status and version registers
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Analog engines report results through ana and done inputs
// Notes on behaviour
// - Page 01 of 2Ch shows VCO range
// - Same page: bit3 one, VCO level low
// - Page 10 of 2Ch shows filter trims
// - Page 00 of 2Dh shows converter result
// - Command 87h converts; result after 20us
// - Source select picks mixer or pin
// - Page 01 of 2Dh bit7 reference type
// - Bits 2..0 show supply level code
// - Bits 6..3 of that page read zero
// - Bit6 flags VCO range commands done, interrupts
// - Bit5 flags supply level commands done
// - Bit4 flags filter calibration done
// - Bit3 flags conversion done, interrupts
// - Bit2 shows anticollision support enabled
// - Bit1 shows gain limiting on or off
// - Bit0 shows auxiliary synthesizer selected
// - 33h returns fixed version code
// - Config field selects 2Ch page
// - Config field selects 2Dh page
// - Enabled completion event drives interrupt high
`timescale 1ns/1ps

module reader_status_display_regs
  import rsd_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE = 8'h5A // Arbitrary value
) (
  input  wire logic         hclk,       // Bus clock
  input  wire logic         hresetn,    // Async reset, active low
  input  wire logic         hsel,       // Slave select
  input  wire logic [31:0]  haddr,      // Byte address
  input  wire logic [1:0]   htrans,     // Transfer type
  input  wire logic         hwrite,     // Write when high
  input  wire logic [2:0]   hsize,      // Transfer size
  input  wire logic         hready,     // Bus ready in
  input  wire logic [31:0]  hwdata,     // Write data
  output logic      [31:0]  hrdata,     // Read data
  output logic              hreadyout,  // Slave ready
  output logic              hresp,      // Always OKAY
  input  wire ana_status_t  ana,        // Analog measurement values
  input  wire engine_done_t done,       // Engine completion pulses
  output logic              cmd_stb,    // Direct command pulse
  output logic      [7:0]   cmd_code,   // Direct command code
  output logic      [1:0]   conv_src,   // Converter source select
  output logic              irq         // Completion interrupt
);

  rsd_state_t  st_r;
  rsd_state_t  st_nxt;
  logic        irq_want;
  logic        acc;
  logic        rd_acc;
  logic        cmd_go;
  logic [7:0]  cmd_val;
  logic [6:0]  set_evt;
  logic [7:0]  rd_byte;
  logic [7:0]  rd_idx;
  logic [1:0]  cal_page;
  logic [1:0]  conv_page;

  assign acc     = hsel & htrans[1] & hready;
  assign rd_acc  = acc & ~hwrite;
  assign rd_idx  = haddr[9:2];
  assign cmd_go  = st_r.wr_pend & (st_r.wr_idx == IDX_COMMAND);
  assign cmd_val = hwdata[7:0];

  always_comb begin
    st_nxt         = st_r;
    set_evt        = 7'h00;
    rd_byte        = 8'h00;
    cal_page       = 2'h0;
    conv_page      = 2'h0;
    st_nxt.cmd_stb = 1'b0;
    st_nxt.wr_pend = acc & hwrite & (hsize == 3'h2);
    st_nxt.wr_idx  = rd_idx;

    // Data phase of a write; display slots have no storage
    if (st_r.wr_pend) begin
      case (st_r.wr_idx)
        IDX_CONFIG:  st_nxt.cfg    = hwdata[7:0];
        IDX_IRQEN:   st_nxt.irq_en = hwdata[7:0];
        default:     st_nxt.cfg    = st_nxt.cfg;
      endcase
    end

    if (cmd_go) begin
      st_nxt.cmd_stb  = 1'b1;
      st_nxt.cmd_code = cmd_val;
      case (cmd_val)
        CMD_VCO_AUT, CMD_VCO_MAN:   st_nxt.flags[ST_VCO]  = 1'b0;
        CMD_SUPP_AUT, CMD_SUPP_MAN: st_nxt.flags[ST_SUPP] = 1'b0;
        CMD_FCAL:     st_nxt.flags[ST_FCAL] = 1'b0;
        CMD_ADC: begin
          st_nxt.flags[ST_ADC] = 1'b0;
          st_nxt.conv_busy     = 1'b1;
          st_nxt.conv_cnt      = CONV_CYCLES;
        end
        CMD_AGL_ON:   st_nxt.flags[ST_AGL] = 1'b1;
        CMD_AGL_OFF:  st_nxt.flags[ST_AGL] = 1'b0;
        CMD_HOP_AUX:  st_nxt.flags[ST_AUX] = 1'b1;
        CMD_HOP_MAIN: st_nxt.flags[ST_AUX] = 1'b0;
        default:      st_nxt.cmd_code = cmd_val;
      endcase
    end

    // Conversion settles, then the selected input is captured
    if (st_r.conv_busy && !(cmd_go && cmd_val == CMD_ADC)) begin
      st_nxt.conv_cnt = st_r.conv_cnt - 12'h001;
      if (st_r.conv_cnt == 12'h001) begin
        st_nxt.conv_busy = 1'b0;
        set_evt[ST_ADC]  = 1'b1;
        case (st_r.cfg[CFG_MSEL_LSB +: 2])
          MSEL_MIX_I: st_nxt.adc = ana.mixer_i_dc;
          MSEL_MIX_Q: st_nxt.adc = ana.mixer_q_dc;
          default:    st_nxt.adc = ana.ext_pin_dc;
        endcase
      end
    end

    // Engine done sets win over a clear in the same cycle; a new 87h command cancels a conversion end instead
    set_evt[ST_VCO]  = done.vco_done;
    set_evt[ST_SUPP] = done.supply_done;
    set_evt[ST_FCAL] = done.filter_done;
    st_nxt.flags[ST_VCO]  = st_nxt.flags[ST_VCO]  | set_evt[ST_VCO];
    st_nxt.flags[ST_SUPP] = st_nxt.flags[ST_SUPP] | set_evt[ST_SUPP];
    st_nxt.flags[ST_FCAL] = st_nxt.flags[ST_FCAL] | set_evt[ST_FCAL];
    st_nxt.flags[ST_ADC]  = st_nxt.flags[ST_ADC]  | set_evt[ST_ADC];
    st_nxt.flags[ST_ACOL] = ana.anticollision_support_on;

    // Interrupt follows enabled completion events
    irq_want   = |(set_evt[6:3] & st_r.irq_en[6:3]);
    st_nxt.irq = irq_want;

    // Read mux sees this cycle's writes and flag updates
    cal_page  = st_nxt.cfg[CFG_CALPG_LSB +: 2];
    conv_page = st_nxt.cfg[CFG_CONVPG_LSB +: 2];
    case (rd_idx)
      IDX_CALIB: begin
        if (cal_page == PAGE_VCO) begin
          rd_byte = {ana.vco_range, 1'b1, ana.vco_level};
        end else if (cal_page == PAGE_FILTER) begin
          rd_byte = {ana.highpass_trim_code,
                     ana.lowpass_trim_code};
        end
      end
      IDX_CONV: begin
        if (conv_page == PAGE_ADC) begin
          rd_byte = st_nxt.adc;
        end else if (conv_page == PAGE_OSC) begin
          rd_byte = {ana.tcxo_detected, 4'h0,
                     ana.supply_level_code};
        end
      end
      IDX_CMDST:   rd_byte = {1'b0, st_nxt.flags};
      IDX_CONFIG:  rd_byte = st_nxt.cfg;
      IDX_IRQEN:   rd_byte = st_nxt.irq_en;
      IDX_VERSION: rd_byte = VERSION_CODE;
      default:     rd_byte = 8'h00;
    endcase
    if (rd_acc) begin
      st_nxt.hrdata = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r  <= '0;
      st_r.cfg    <= CFG_RST;
      st_r.irq_en <= IRQEN_RST;
    end else begin
      st_r  <= st_nxt;
    end
  end

  assign hrdata    = st_r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign cmd_stb   = st_r.cmd_stb;
  assign cmd_code  = st_r.cmd_code;
  assign conv_src  = st_r.cfg[CFG_MSEL_LSB +: 2];
  assign irq       = st_r.irq;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_adc_cmd;
    cmd_go && cmd_val == CMD_ADC;
  endsequence

  sequence s_conv_last;
    st_r.conv_busy && st_r.conv_cnt == 12'h001
    && !(cmd_go && cmd_val == CMD_ADC);
  endsequence

  a_conv_start: assert property (
    s_adc_cmd |=> !st_r.flags[ST_ADC] && st_r.conv_busy
                  && st_r.conv_cnt == CONV_CYCLES)
    else $error("conversion did not start on command");

  a_conv_finish: assert property (
    s_conv_last |=> st_r.flags[ST_ADC] && !st_r.conv_busy)
    else $error("conversion flag not set at end");

  a_conv_early: assert property (
    st_r.conv_busy && st_r.conv_cnt > 12'h001 |=> !st_r.flags[ST_ADC])
    else $error("conversion flag set too early");

  a_irq_event: assert property (
    (|(set_evt[6:3] & st_r.irq_en[6:3])) |=> irq)
    else $error("enabled event gave no interrupt");

  a_irq_cause: assert property (
    irq |-> $past(irq_want))
    else $error("interrupt without enabled event");

  a_vco_set_wins: assert property (
    done.vco_done |=> st_r.flags[ST_VCO])
    else $error("vco flag lost its set");

  a_aux_select: assert property (
    cmd_go && cmd_val == CMD_HOP_AUX |=> st_r.flags[ST_AUX])
    else $error("aux select not shown");

  a_agl_off: assert property (
    cmd_go && cmd_val == CMD_AGL_OFF |=> !st_r.flags[ST_AGL])
    else $error("gain limiting still shown on");

  a_version_read: assert property (
    rd_acc && rd_idx == IDX_VERSION |=> hrdata == {24'h00_0000,
                                                    VERSION_CODE})
    else $error("version read wrong");

  a_vco_page: assert property (
    rd_acc && rd_idx == IDX_CALIB && cal_page == PAGE_VCO
    |=> hrdata[3] && hrdata[31:8] == 24'h00_0000)
    else $error("vco page bit three not one");

  a_osc_reserved: assert property (
    rd_acc && rd_idx == IDX_CONV && conv_page == PAGE_OSC
    |=> hrdata[6:3] == 4'h0)
    else $error("reserved bits not zero");

  a_display_ro: assert property (
    st_r.wr_pend && st_r.wr_idx == IDX_CMDST && !cmd_go
    |=> $stable(st_r.cfg) && $stable(st_r.irq_en))
    else $error("display write changed state");

  a_cmd_pulse: assert property (
    cmd_go |=> cmd_stb && cmd_code == $past(cmd_val))
    else $error("command strobe missing");

  a_cmd_single: assert property (
    cmd_go ##1 !cmd_go |=> !cmd_stb)
    else $error("command strobe not one cycle");

  // Read pages and command status
  sequence s_calib_read;
    rd_acc && rd_idx == IDX_CALIB;
  endsequence

  sequence s_conv_read;
    rd_acc && rd_idx == IDX_CONV;
  endsequence

  sequence s_status_read;
    rd_acc && rd_idx == IDX_CMDST;
  endsequence

  a_vco_fields: assert property (
    s_calib_read ##0 cal_page == PAGE_VCO
    |=> hrdata[7:4] == $past(ana.vco_range)
        && hrdata[2:0] == $past(ana.vco_level))
    else $error("vco page fields wrong");

  a_filter_page: assert property (
    s_calib_read ##0 cal_page == PAGE_FILTER
    |=> hrdata[7:4] == $past(ana.highpass_trim_code)
        && hrdata[3:0] == $past(ana.lowpass_trim_code))
    else $error("filter page fields wrong");

  a_calib_unused: assert property (
    s_calib_read ##0 cal_page != PAGE_VCO && cal_page != PAGE_FILTER
    |=> hrdata == 32'h0000_0000)
    else $error("unused calibration page not zero");

  a_adc_page: assert property (
    s_conv_read ##0 conv_page == PAGE_ADC
    |=> hrdata == {24'h00_0000, st_r.adc})
    else $error("converter page wrong");

  a_osc_type: assert property (
    s_conv_read ##0 conv_page == PAGE_OSC
    |=> hrdata[7] == $past(ana.tcxo_detected))
    else $error("reference type bit wrong");

  a_supply_code: assert property (
    s_conv_read ##0 conv_page == PAGE_OSC
    |=> hrdata[2:0] == $past(ana.supply_level_code))
    else $error("supply level code wrong");

  a_conv_unused: assert property (
    s_conv_read ##0 conv_page != PAGE_ADC && conv_page != PAGE_OSC
    |=> hrdata == 32'h0000_0000)
    else $error("unused converter page not zero");

  a_status_read: assert property (
    s_status_read |=> hrdata == {25'h000_0000, st_r.flags})
    else $error("command status read wrong");

  a_acol_follow: assert property (
    $past(hresetn) |-> st_r.flags[ST_ACOL]
                       == $past(ana.anticollision_support_on))
    else $error("anticollision bit does not follow");

  a_supp_set: assert property (
    done.supply_done |=> st_r.flags[ST_SUPP])
    else $error("supply flag not set");

  a_fcal_set: assert property (
    done.filter_done |=> st_r.flags[ST_FCAL])
    else $error("filter flag not set");

  a_vco_irq: assert property (
    done.vco_done && st_r.irq_en[ST_VCO] |=> irq)
    else $error("vco completion gave no interrupt");

  a_supp_irq: assert property (
    done.supply_done && st_r.irq_en[ST_SUPP] |=> irq)
    else $error("supply completion gave no interrupt");

  a_fcal_irq: assert property (
    done.filter_done && st_r.irq_en[ST_FCAL] |=> irq)
    else $error("filter completion gave no interrupt");

  a_vco_clear: assert property (
    cmd_go && (cmd_val == CMD_VCO_AUT || cmd_val == CMD_VCO_MAN)
    && !done.vco_done |=> !st_r.flags[ST_VCO])
    else $error("vco flag not cleared on issue");

  a_flag_hold: assert property (
    st_r.flags[ST_FCAL] && !cmd_go |=> st_r.flags[ST_FCAL])
    else $error("filter flag dropped");

  a_agl_on: assert property (
    cmd_go && cmd_val == CMD_AGL_ON |=> st_r.flags[ST_AGL])
    else $error("gain limiting not shown on");

  a_main_select: assert property (
    cmd_go && cmd_val == CMD_HOP_MAIN |=> !st_r.flags[ST_AUX])
    else $error("main select not shown");

  a_cfg_write: assert property (
    st_r.wr_pend && st_r.wr_idx == IDX_CONFIG
    |=> st_r.cfg == $past(cmd_val))
    else $error("config write lost");

  a_conv_step: assert property (
    st_r.conv_busy && st_r.conv_cnt > 12'h001 && !cmd_go
    |=> st_r.conv_busy
        && st_r.conv_cnt == $past(st_r.conv_cnt) - 12'h001)
    else $error("conversion count did not step");

  a_src_mix_i: assert property (
    s_conv_last ##0 st_r.cfg[CFG_MSEL_LSB +: 2] == MSEL_MIX_I
    |=> st_r.adc == $past(ana.mixer_i_dc))
    else $error("mixer I level not captured");

  a_src_mix_q: assert property (
    s_conv_last ##0 st_r.cfg[CFG_MSEL_LSB +: 2] == MSEL_MIX_Q
    |=> st_r.adc == $past(ana.mixer_q_dc))
    else $error("mixer Q level not captured");

  a_src_pin: assert property (
    s_conv_last ##0 st_r.cfg[CFG_MSEL_LSB + 1]
    |=> st_r.adc == $past(ana.ext_pin_dc))
    else $error("pin level not captured");

  a_conv_irq: assert property (
    s_conv_last ##0 st_r.irq_en[ST_ADC] |=> irq)
    else $error("conversion gave no interrupt");

  a_hrdata_hold: assert property (
    !rd_acc |=> $stable(hrdata))
    else $error("read data changed without a read");

endmodule

// File: hdl/rsd_pkg.sv
// Purpose: Shared constants and carriers for the status display bank
// Assumes: 200 MHz bus clock, word-aligned register slots
// Notes:   Slot byte address is four times the register index
package rsd_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CALIB   = 8'h2C;
  localparam logic [7:0] IDX_CONV    = 8'h2D;
  localparam logic [7:0] IDX_CMDST   = 8'h2E;
  localparam logic [7:0] IDX_CONFIG  = 8'h30;
  localparam logic [7:0] IDX_COMMAND = 8'h31;
  localparam logic [7:0] IDX_IRQEN   = 8'h32;
  localparam logic [7:0] IDX_VERSION = 8'h33;

  // Page codes
  localparam logic [1:0] PAGE_VCO    = 2'h1;
  localparam logic [1:0] PAGE_FILTER = 2'h2;
  localparam logic [1:0] PAGE_ADC    = 2'h0;
  localparam logic [1:0] PAGE_OSC    = 2'h1;

  // Config register fields and resets
  localparam int         CFG_CONVPG_LSB = 6;
  localparam int         CFG_CALPG_LSB  = 4;
  localparam int         CFG_MSEL_LSB   = 0;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [7:0] IRQEN_RST      = 8'h78;

  // Converter source codes
  localparam logic [1:0] MSEL_MIX_I = 2'h0;
  localparam logic [1:0] MSEL_MIX_Q = 2'h1;

  // Direct command codes
  localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
  localparam logic [7:0] CMD_HOP_AUX  = 8'h85;
  localparam logic [7:0] CMD_ADC      = 8'h87;
  localparam logic [7:0] CMD_FCAL     = 8'h88;
  localparam logic [7:0] CMD_SUPP_AUT = 8'hA2;
  localparam logic [7:0] CMD_SUPP_MAN = 8'hA3;
  localparam logic [7:0] CMD_VCO_AUT  = 8'hA4;
  localparam logic [7:0] CMD_VCO_MAN  = 8'hA5;
  localparam logic [7:0] CMD_AGL_ON   = 8'hA6;
  localparam logic [7:0] CMD_AGL_OFF  = 8'hA7;

  // Command status bit positions
  localparam int ST_VCO  = 6;
  localparam int ST_SUPP = 5;
  localparam int ST_FCAL = 4;
  localparam int ST_ADC  = 3;
  localparam int ST_ACOL = 2;
  localparam int ST_AGL  = 1;
  localparam int ST_AUX  = 0;

  // Conversion settle time
  localparam int          CONV_TIME_NS  = 20000;
  localparam int          CLK_PERIOD_NS = 5;
  localparam logic [11:0] CONV_CYCLES   =
    12'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic [3:0] vco_range;
    logic [2:0] vco_level;
    logic [3:0] highpass_trim_code;
    logic [3:0] lowpass_trim_code;
    logic       tcxo_detected;
    logic [2:0] supply_level_code;
    logic       anticollision_support_on;
    logic [7:0] mixer_i_dc;
    logic [7:0] mixer_q_dc;
    logic [7:0] ext_pin_dc;
  } ana_status_t;

  typedef struct packed {
    logic vco_done;
    logic supply_done;
    logic filter_done;
  } engine_done_t;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] hrdata;
    logic [7:0]  cfg;
    logic [7:0]  irq_en;
    logic [6:0]  flags;
    logic        conv_busy;
    logic [11:0] conv_cnt;
    logic [7:0]  adc;
    logic        cmd_stb;
    logic [7:0]  cmd_code;
    logic        irq;
  } rsd_state_t;

endpackage

// File: tb/tb_reader_status_display_regs.sv
// Purpose: Self-checking bench for the status display bank
// Assumes: hready tied to hreadyout, word transfers plus one byte-sized write
// Notes:   Flag, converter and interrupt models kept in the bench
`timescale 1ns/1ps
module tb_reader_status_display_regs;
  import rsd_pkg::*;
  localparam logic [7:0] VER = 8'h3C; // Arbitrary value
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_stb, irq;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans, conv_src;
  logic [2:0]   hsize;
  logic [7:0]   cmd_code, madc;
  logic [6:0]   mflags;
  ana_status_t  ana;
  engine_done_t done;
  int           miscompares, checks_done, irqs, mirq, n;
  logic [7:0]   cl[5] = '{CMD_VCO_AUT, CMD_VCO_MAN, CMD_SUPP_AUT,
                          CMD_SUPP_MAN, CMD_FCAL};
  int           pb[5] = '{4, 4, 2, 2, 1};
  int           fb[5] = '{ST_VCO, ST_VCO, ST_SUPP, ST_SUPP, ST_FCAL};
  logic [7:0]   tl[6] = '{CMD_AGL_ON, CMD_AGL_OFF, CMD_AGL_ON,
                          CMD_HOP_AUX, CMD_HOP_MAIN, CMD_HOP_AUX};

  reader_status_display_regs #(.VERSION_CODE(VER)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ana(ana), .done(done), .cmd_stb(cmd_stb), .cmd_code(cmd_code),
    .conv_src(conv_src), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  always @(posedge hclk) if (irq === 1'b1) irqs <= irqs + 1;

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic ana_status_t rnd();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return ana_status_t'(r[$bits(ana_status_t)-1:0]);
  endfunction

  function automatic logic [31:0] st();
    return {24'h0, 1'b0, mflags[6:3], ana.anticollision_support_on,
            mflags[1:0]};
  endfunction

  // One bus transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cmd(input logic [7:0] c);
    xfer(1'b1, IDX_COMMAND, {24'h0, c});
    @(posedge hclk);
    chk(32'(cmd_stb), 32'h1);
    chk(32'(cmd_code), 32'(c));
    case (c)
      CMD_VCO_AUT, CMD_VCO_MAN:   mflags[ST_VCO] = 1'b0;
      CMD_SUPP_AUT, CMD_SUPP_MAN: mflags[ST_SUPP] = 1'b0;
      CMD_FCAL:                   mflags[ST_FCAL] = 1'b0;
      CMD_ADC:                    mflags[ST_ADC] = 1'b0;
      CMD_AGL_ON, CMD_AGL_OFF:    mflags[ST_AGL] = (c == CMD_AGL_ON);
      default:                    mflags[ST_AUX] = (c == CMD_HOP_AUX);
    endcase
  endtask

  task automatic eng(input int i, input logic en);
    cmd(cl[i]);
    rc(IDX_CMDST, st());
    done <= engine_done_t'(3'(pb[i]));
    @(posedge hclk);
    done <= '0;
    repeat (2) @(posedge hclk);
    mflags[fb[i]] = 1'b1;
    mirq += int'(en);
    rc(IDX_CMDST, st());
    chk(irqs, mirq);
  endtask

  initial begin
    #100000;
    miscompares++;
    conclude();
  end

  initial begin
    void'($urandom(80168));
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    done = '0;
    ana = rnd();
    mflags = '0;
    madc = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(IDX_VERSION, 32'(VER));
    xfer(1'b1, IDX_VERSION, 32'hFFFF_FFFF);
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
    rc(IDX_VERSION, 32'(VER));
    rc(IDX_IRQEN, 32'(IRQEN_RST));
    rc(8'hFF, 32'h0);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, IDX_CONFIG, {24'h0, 2'(p), 2'(p), 4'h0});
      ana <= rnd();
      xfer(1'b1, IDX_CALIB, 32'hFFFF_FFFF);
      rc(IDX_CALIB, p == 1 ? {24'h0, ana.vco_range, 1'b1, ana.vco_level} :
         p == 2 ? {24'h0, ana.highpass_trim_code, ana.lowpass_trim_code} :
         32'h0);
      rc(IDX_CONV, p == 1 ? {24'h0, ana.tcxo_detected, 4'h0,
         ana.supply_level_code} :
         p == 0 ? {24'h0, madc} : 32'h0);
    end
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, IDX_CONFIG, 32'(s));
      ana <= rnd();
      cmd(CMD_ADC);
      rc(IDX_CMDST, st());
      n = 3;
      do begin
        @(posedge hclk);
        n++;
      end while (irq !== 1'b1 && n < 5000);
      chk(n, 32'(CONV_CYCLES) + 1);
      mirq++;
      mflags[ST_ADC] = 1'b1;
      madc = s == 0 ? ana.mixer_i_dc :
             s == 1 ? ana.mixer_q_dc : ana.ext_pin_dc;
      chk(32'(conv_src), 32'(s));
      rc(IDX_CONV, {24'h0, madc});
      rc(IDX_CMDST, st());
    end
    // Byte-sized write must not move the page select
    hsize <= 3'h0;
    xfer(1'b1, IDX_CONFIG, 32'h0000_0040);
    hsize <= 3'h2;
    rc(IDX_CONV, {24'h0, madc});
    for (int i = 0; i < 5; i++) eng(i, 1'b1);
    xfer(1'b1, IDX_IRQEN, 32'h0);
    eng(0, 1'b0);
    xfer(1'b1, IDX_IRQEN, 32'h78);
    for (int i = 0; i < 6; i++) begin
      ana <= rnd();
      cmd(tl[i]);
      rc(IDX_CMDST, st());
    end
    xfer(1'b1, IDX_CMDST, 32'h0);
    rc(IDX_CMDST, st());
    conclude();
  end
endmodule
